// [rtl/cdtp_defines.vh]
// constants for the prescaled count-down timer: register indices, fields, reset values
// assumes a 32-bit AHB-Lite bus; each register index sits at byte address index * 4
`ifndef CDTP_DEFINES_VH
`define CDTP_DEFINES_VH

// register indices; byte address is index * 4
`define CDTP_IDX_COUNT 6'h08
`define CDTP_IDX_CTRL 6'h09
`define CDTP_IDX_EVT_STAT 6'h0a
`define CDTP_IDX_EVT_CLR 6'h0b
`define CDTP_IDX_EVT_EN 6'h0c
`define CDTP_IDX_SYS 6'h0d

// timer_control fields
`define CDTP_CTRL_FLAG 7
`define CDTP_CTRL_MASK 6
`define CDTP_CTRL_EXT 5
`define CDTP_CTRL_GATE 4
`define CDTP_CTRL_PCLR 3
`define CDTP_CTRL_RATIO_HI 2

// system control fields
`define CDTP_SYS_GMASK 0
`define CDTP_SYS_STOP 1
`define CDTP_SYS_WAIT 2
`define CDTP_SYS_STOP_EXIT 3

// event bits
`define CDTP_EVT_ZERO 0
`define CDTP_EVT_WAKE 1
`define CDTP_EVT_N 2

// reset values
`define CDTP_COUNT_RST 8'hff
`define CDTP_RATIO_RST 3'h4
`define CDTP_MASK_RST 1'b1
`define CDTP_GMASK_RST 1'b1

// clock source selections {ext, gate}
`define CDTP_SRC_INT 2'h0
`define CDTP_SRC_AND 2'h1
`define CDTP_SRC_OFF 2'h2
`define CDTP_SRC_PIN 2'h3

// service vector pair of the timer interrupt
`define CDTP_VEC_LO 16'h1ff6
`define CDTP_VEC_HI 16'h1ff7

`endif

// [rtl/cdtp_timer.v]
// prescaled 8-bit count-down timer with AHB-Lite register slave and event interrupt
// assumes one 100 MHz clock, synchronous active-high reset, single word transfers only
//
// How it works
// R1 - software-presettable 8-bit counter decrements once per prescaler output tick
// R2 - reaching zero by decrement sets count_zero_flag, held until software clears it
// R3 - cpu request only while flag set, timer mask clear, global mask clear
// R4 - taken timer interrupt fetches its routine address from vector pair 1ff6/1ff7
// R5 - counter keeps decrementing past zero and wraps to ff
// R6 - count reads return live value, stable through the read data phase
// R7 - flag cleared by reset or by writing zero to its control bit
// R8 - a write to the timer drops a pending, unserviced timer interrupt
// R9 - reset sets the timer mask; mask gates the cpu request and the wait wake request
// R10 - 3-bit ratio selects divide by 2**n, 1 to 128; reset ratio 100
// R11 - prescaler unreadable; writing one to prescaler_clear zeroes it; bit reads zero
// R12 - source bits: 00 internal, 01 internal and pin, 10 off, 11 pin
// R13 - reset clears both source bits so the timer runs on the internal clock
// R14 - count register reads live value, resets to ff, writes preset the counter
// R15 - software sets prescaler_clear whenever it loads a new count
// R16 - stop halts counting; stop exit zeroes counter, sets flag, resumes
// R17 - counting continues in wait; enabled timer interrupt wakes the processor
// R18 - free-running 7-bit prescaler; chosen tap gives one decrement per full period
`include "cdtp_defines.vh"

module cdtp_timer #(
    parameter PRESC_W = 7
) (
    input wire clock,
    input wire sys_rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire timer_pin,
    output reg timer_irq_req,
    output reg [15:0] timer_vec_addr,
    output reg wake_req,
    output reg irq
);

    reg pin_meta_reg;
    reg pin_sync_reg;
    reg pin_prev_reg;
    reg [7:0] count_reg;
    reg [PRESC_W-1:0] presc_reg;
    reg count_zero_flag_reg;
    reg timer_irq_mask_reg;
    reg ext_clock_select_reg;
    reg pin_input_gate_reg;
    reg [2:0] ratio_reg;
    reg gmask_reg;
    reg stop_reg;
    reg wait_reg;
    reg [`CDTP_EVT_N-1:0] evt_stat_reg;
    reg [`CDTP_EVT_N-1:0] evt_en_reg;
    reg dp_wr_reg;
    reg dp_rd_reg;
    reg [5:0] dp_idx_reg;

    wire addr_take = hsel & htrans[1] & hready;
    wire wr_go = dp_wr_reg;
    wire [7:0] wdat = hwdata[7:0];
    wire wr_count = wr_go && dp_idx_reg == `CDTP_IDX_COUNT;
    wire wr_ctrl = wr_go && dp_idx_reg == `CDTP_IDX_CTRL;
    wire wr_clr = wr_go && dp_idx_reg == `CDTP_IDX_EVT_CLR;
    wire wr_en = wr_go && dp_idx_reg == `CDTP_IDX_EVT_EN;
    wire wr_sys = wr_go && dp_idx_reg == `CDTP_IDX_SYS;
    wire stop_exit = wr_sys & wdat[`CDTP_SYS_STOP_EXIT] & stop_reg;

    // clock source select; pin edge is taken from synced copies only
    reg src_tick;
    always @* begin
        case ({ext_clock_select_reg, pin_input_gate_reg}) // see R12
            `CDTP_SRC_INT: src_tick = 1'b1;
            `CDTP_SRC_AND: src_tick = pin_sync_reg;
            `CDTP_SRC_OFF: src_tick = 1'b0;
            `CDTP_SRC_PIN: src_tick = pin_sync_reg & ~pin_prev_reg;
            default: src_tick = 1'b0;
        endcase
    end

    wire run_tick = src_tick & ~stop_reg; // see R16 R17
    wire [7:0] one_sh = 8'h01 << ratio_reg;
    wire [7:0] mask8 = one_sh - 8'h01;
    // tap fires when the low n prescaler bits are all ones, i.e. a full 2**n period ends
    wire tap_hit = run_tick && ((presc_reg | ~mask8[PRESC_W-1:0]) == {PRESC_W{1'b1}}); // see R10 R18
    wire hit_zero = tap_hit && !wr_count && count_reg == 8'h01; // see R2
    wire flag_set = hit_zero | stop_exit;
    wire req_now = count_zero_flag_reg & ~timer_irq_mask_reg & ~gmask_reg; // see R3 R9
    wire wake_now = req_now & wait_reg; // see R17
    wire [`CDTP_EVT_N-1:0] evt_pulse;
    assign evt_pulse[`CDTP_EVT_ZERO] = flag_set;
    assign evt_pulse[`CDTP_EVT_WAKE] = wake_now & ~wake_req;

    always @(posedge clock) begin
        if (sys_rst) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= timer_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // prescaler has no reset; only a prescaler_clear write zeroes it
    always @(posedge clock) begin
        if (wr_ctrl && wdat[`CDTP_CTRL_PCLR]) begin
            presc_reg <= {PRESC_W{1'b0}}; // see R11 R15
        end else if (run_tick) begin
            presc_reg <= presc_reg + {{(PRESC_W-1){1'b0}}, 1'b1}; // see R18
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            count_reg <= `CDTP_COUNT_RST; // see R14
        end else if (wr_count) begin
            count_reg <= wdat; // see R1 R14
        end else if (stop_exit) begin
            count_reg <= 8'h00; // see R16
        end else if (tap_hit) begin
            count_reg <= count_reg - 8'h01; // see R1 R5
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            count_zero_flag_reg <= 1'b0; // see R7
            timer_irq_mask_reg <= `CDTP_MASK_RST; // see R9
            ext_clock_select_reg <= 1'b0; // see R13
            pin_input_gate_reg <= 1'b0; // see R13
            ratio_reg <= `CDTP_RATIO_RST; // see R10
        end else begin
            // set wins over a control-bit clear in the same cycle; a count write blocks the set at zero
            if (flag_set) begin
                count_zero_flag_reg <= 1'b1; // see R2 R16
            end else if (wr_count || (wr_ctrl && !wdat[`CDTP_CTRL_FLAG])) begin
                count_zero_flag_reg <= 1'b0; // see R7 R8
            end
            if (wr_ctrl) begin
                timer_irq_mask_reg <= wdat[`CDTP_CTRL_MASK];
                ext_clock_select_reg <= wdat[`CDTP_CTRL_EXT];
                pin_input_gate_reg <= wdat[`CDTP_CTRL_GATE];
                ratio_reg <= wdat[`CDTP_CTRL_RATIO_HI:0];
            end
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            gmask_reg <= `CDTP_GMASK_RST;
            stop_reg <= 1'b0;
            wait_reg <= 1'b0;
        end else begin
            if (wr_sys) begin
                gmask_reg <= wdat[`CDTP_SYS_GMASK];
                wait_reg <= wdat[`CDTP_SYS_WAIT];
            end else if (wake_now) begin
                wait_reg <= 1'b0; // see R17
            end
            if (stop_exit) begin
                stop_reg <= 1'b0; // see R16
            end else if (wr_sys) begin
                stop_reg <= wdat[`CDTP_SYS_STOP];
            end
        end
    end

    // sticky event bits; a clear in the same cycle as a new event loses
    genvar gi;
    generate
        for (gi = 0; gi < `CDTP_EVT_N; gi = gi + 1) begin : g_evt
            always @(posedge clock) begin
                if (sys_rst) begin
                    evt_stat_reg[gi] <= 1'b0;
                end else if (evt_pulse[gi]) begin
                    evt_stat_reg[gi] <= 1'b1;
                end else if (wr_clr && wdat[gi]) begin
                    evt_stat_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge clock) begin
        if (sys_rst) begin
            evt_en_reg <= {`CDTP_EVT_N{1'b0}};
        end else if (wr_en) begin
            evt_en_reg <= wdat[`CDTP_EVT_N-1:0];
        end
    end

    reg [7:0] rd_val;
    always @* begin
        case (dp_idx_reg)
            `CDTP_IDX_COUNT: rd_val = count_reg; // see R6 R14
            `CDTP_IDX_CTRL: rd_val = {count_zero_flag_reg, timer_irq_mask_reg, ext_clock_select_reg,
                                      pin_input_gate_reg, 1'b0, ratio_reg}; // see R11
            `CDTP_IDX_EVT_STAT: rd_val = {6'h00, evt_stat_reg};
            `CDTP_IDX_EVT_EN: rd_val = {6'h00, evt_en_reg};
            `CDTP_IDX_SYS: rd_val = {5'h00, wait_reg, stop_reg, gmask_reg};
            default: rd_val = 8'h00;
        endcase
    end

    // reads take one wait state so a write just before is already visible
    always @(posedge clock) begin
        if (sys_rst) begin
            dp_wr_reg <= 1'b0;
            dp_rd_reg <= 1'b0;
            dp_idx_reg <= 6'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (dp_rd_reg) begin
                hrdata <= {24'h00_0000, rd_val}; // see R6
                hreadyout <= 1'b1;
                dp_rd_reg <= 1'b0;
            end else begin
                dp_wr_reg <= addr_take & hwrite & (haddr[1:0] == 2'b00);
                dp_rd_reg <= addr_take & ~hwrite;
                if (addr_take) begin
                    dp_idx_reg <= haddr[7:2];
                    hreadyout <= hwrite;
                end
            end
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            timer_irq_req <= 1'b0;
            wake_req <= 1'b0;
            irq <= 1'b0;
            timer_vec_addr <= `CDTP_VEC_LO;
        end else begin
            timer_irq_req <= req_now; // see R3
            wake_req <= wake_now; // see R17
            irq <= |(evt_stat_reg & evt_en_reg);
            timer_vec_addr <= `CDTP_VEC_LO; // see R4
        end
    end

endmodule // cdtp_timer

// [bench/cdtp_timer_monitor.sv]
// port assertions for the prescaled count-down timer
// assumes one clock with synchronous active-high sys_rst
module cdtp_timer_monitor #(
    parameter PRESC_W = 7
) (
    input logic clock,
    input logic sys_rst,
    input logic hsel,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hready,
    input logic [31:0] hrdata,
    input logic hreadyout,
    input logic hresp,
    input logic timer_irq_req,
    input logic [15:0] timer_vec_addr,
    input logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence read_taken;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_one_wait: assert property (read_taken |=> one_wait)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
        else $error("write stalled");
    a_wait_single: assert property (!hreadyout |=> hreadyout)
        else $error("wait state too long");
    a_rdata_held: assert property (hreadyout ##1 hreadyout |-> $stable(hrdata))
        else $error("read data moved outside a read");
    a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_resp_okay: assert property (!hresp)
        else $error("error response seen");
    a_vector_fixed: assert property (timer_vec_addr == 16'h1ff6)
        else $error("vector address wrong");
    a_reset_quiet: assert property ($fell(sys_rst) |-> hreadyout && !irq && !timer_irq_req && hrdata == 32'h0000_0000)
        else $error("outputs not idle after reset");
endmodule // cdtp_timer_monitor

bind cdtp_timer cdtp_timer_monitor #(.PRESC_W(PRESC_W)) mon_u (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_irq_req(timer_irq_req), .timer_vec_addr(timer_vec_addr), .irq(irq));

// [bench/cdtp_cpu_model.sv]
// bus master standing in for the cpu core on the timer's register bus
// assumes one slave whose hreadyout is hready; single word transfers only
module cdtp_cpu_model (
    input logic clock,
    input logic hready,
    input logic [31:0] hrdata,
    output logic hsel = 1'b0,
    output logic [31:0] haddr = 32'h0000_0000,
    output logic [1:0] htrans = 2'h0,
    output logic hwrite = 1'b0,
    output logic [2:0] hsize = 3'h2,
    output logic [31:0] hwdata = 32'h0000_0000
);
    // ready and read data sampled at rising edges; everything changes just after one
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'b1 && n < 100);
        q = hrdata;
        if (hready !== 1'b1) testbench.hang();
    endtask
endmodule // cdtp_cpu_model

// [bench/testbench.sv]
// self-checking bench for the prescaled count-down timer
// assumes the cpu model drives the register bus; timer pin is driven here
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic timer_pin = 1'b0;
    wire hsel, hwrite, hready, hresp, timer_irq_req, wake_req, irq;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [15:0] vec_addr;
    logic wake_seen = 1'b0;
    int err_count = 0;
    int n_compared = 0;
    logic [31:0] q;
    always #5 clock = ~clock;
    // wake request is a one-cycle pulse; keep it for a later compare
    always @(posedge clock) begin
        if (wake_req === 1'b1) wake_seen <= 1'b1;
    end
    cdtp_timer #(.PRESC_W(7)) dut_u (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .timer_pin(timer_pin), .timer_irq_req(timer_irq_req), .timer_vec_addr(vec_addr),
        .wake_req(wake_req),
        .irq(irq));
    cdtp_cpu_model cpu_u (.clock(clock), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        cpu_u.xfer(a, 1'b1, d, x);
    endtask
    task automatic rd(input logic [31:0] a);
        cpu_u.xfer(a, 1'b0, 32'h0000_0000, q);
    endtask
    task automatic chk_reg(input string s, input logic [31:0] e);
        n_compared++;
        if (q !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", s, e, q);
        end
    endtask
    task automatic chk_bit(input string s, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %b, seen %b", s, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic hang();
        err_count++;
        give_verdict();
    endtask
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        rd(32'h0000_0020);
        chk_reg("count reset", 32'h0000_00ff);
        rd(32'h0000_0024);
        chk_reg("control reset", 32'h0000_0044);
        $display("test reset values done");
        wr(32'h0000_0034, 32'h0000_0000);
        wr(32'h0000_0030, 32'h0000_0001);
        wr(32'h0000_0024, 32'h0000_0008);
        rd(32'h0000_0024);
        chk_reg("prescaler clear reads zero", 32'h0000_0000);
        wr(32'h0000_0020, 32'h0000_0006);
        repeat (20) @(posedge clock);
        rd(32'h0000_0024);
        chk_reg("flag after zero", 32'h0000_0080);
        chk_bit("cpu request", 1'b1, timer_irq_req);
        rd(32'h0000_0020);
        chk_bit("count wrapped", 1'b1, q[7:0] > 8'he0);
        chk_bit("irq level", 1'b1, irq);
        wr(32'h0000_0030, 32'h0000_0000);
        rd(32'h0000_0028);
        chk_reg("event status", 32'h0000_0001);
        chk_bit("irq disabled", 1'b0, irq);
        $display("test count to zero done");
        wr(32'h0000_0024, 32'h0000_00c0);
        rd(32'h0000_0024);
        chk_reg("mask keeps flag", 32'h0000_00c0);
        chk_bit("masked request", 1'b0, timer_irq_req);
        wr(32'h0000_0020, 32'h0000_0080);
        rd(32'h0000_0024);
        chk_reg("count write drops flag", 32'h0000_0040);
        $display("test mask and discard done");
        wr(32'h0000_0024, 32'h0000_00a0);
        wr(32'h0000_0020, 32'h0000_0010);
        repeat (20) @(posedge clock);
        rd(32'h0000_0020);
        chk_reg("clock off holds", 32'h0000_0010);
        wr(32'h0000_0024, 32'h0000_0090);
        wr(32'h0000_0020, 32'h0000_0010);
        repeat (10) @(posedge clock);
        rd(32'h0000_0020);
        chk_reg("gate closed holds", 32'h0000_0010);
        @(posedge clock);
        timer_pin <= 1'b1;
        repeat (8) @(posedge clock);
        timer_pin <= 1'b0;
        rd(32'h0000_0020);
        chk_bit("gate open counts", 1'b1, q[7:0] < 8'h10);
        wr(32'h0000_0024, 32'h0000_00b0);
        wr(32'h0000_0020, 32'h0000_0010);
        repeat (3) begin
            @(posedge clock);
            timer_pin <= 1'b1;
            repeat (4) @(posedge clock);
            timer_pin <= 1'b0;
            repeat (3) @(posedge clock);
        end
        repeat (6) @(posedge clock);
        rd(32'h0000_0020);
        chk_reg("pin edges counted", 32'h0000_000d);
        $display("test clock sources done");
        wr(32'h0000_0030, 32'h0000_0001);
        repeat (3) @(posedge clock);
        chk_bit("irq enabled", 1'b1, irq);
        wr(32'h0000_002c, 32'h0000_0001);
        rd(32'h0000_0028);
        chk_reg("event cleared", 32'h0000_0000);
        chk_bit("irq after clear", 1'b0, irq);
        wr(32'h0000_003c, 32'h0000_00ff);
        rd(32'h0000_003c);
        chk_reg("unmapped reads zero", 32'h0000_0000);
        chk_bit("vector", 1'b1, vec_addr === 16'h1ff6);
        $display("test interrupt and map done");
        wr(32'h0000_0020, 32'h0000_0010);
        wr(32'h0000_0024, 32'h0000_000b);
        repeat (60) @(posedge clock);
        rd(32'h0000_0020);
        chk_reg("divide by 8", 32'h0000_0009);
        wr(32'h0000_0034, 32'h0000_0002);
        wr(32'h0000_0020, 32'h0000_0040);
        wr(32'h0000_0024, 32'h0000_0000);
        repeat (10) @(posedge clock);
        rd(32'h0000_0020);
        chk_reg("stop halts", 32'h0000_0040);
        wr(32'h0000_0034, 32'h0000_0008);
        rd(32'h0000_0024);
        chk_reg("stop exit sets flag", 32'h0000_0080);
        chk_bit("request after exit", 1'b1, timer_irq_req);
        rd(32'h0000_0020);
        chk_bit("resumed from zero", 1'b1, q[7:0] > 8'hf0);
        wr(32'h0000_0024, 32'h0000_0020);
        rd(32'h0000_0024);
        chk_reg("flag write zero clears", 32'h0000_0020);
        wr(32'h0000_0034, 32'h0000_0002);
        wr(32'h0000_0034, 32'h0000_000c);
        rd(32'h0000_0028);
        chk_reg("wake event", 32'h0000_0003);
        rd(32'h0000_0034);
        chk_reg("wait left", 32'h0000_0000);
        chk_bit("wake request", 1'b1, wake_seen);
        $display("test divider and low power done");
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(32'h0000_0024);
        chk_reg("control after reset", 32'h0000_0044);
        $display("test second reset done");
        give_verdict();
    end
endmodule // testbench
